/* common/bhr_consts.svh */
// constants for the byte/halfword reservation unit
`ifndef BHR_CONSTS_SVH
`define BHR_CONSTS_SVH
`define BHR_GPR_W 64
`define BHR_EA_LO_W 32
`define BHR_BYTE_LSB 56
`define BHR_HALF_LSB 48
`define BHR_CR_LT 3
`define BHR_CR_GT 2
`define BHR_CR_EQ 1
`define BHR_CR_SO 0
`define BHR_RSV_RST 1'b0
`define BHR_MEM_TIMEOUT 16
`endif

/* common/bhr_pkg.sv */
// types shared by the byte/halfword reservation unit
package bhr_pkg;
  typedef enum logic [1:0] {
    BHR_OP_LBR,
    BHR_OP_LHR,
    BHR_OP_SBC,
    BHR_OP_SHC
  } bhr_op_t;

  // one instruction from the pipeline
  typedef struct packed {
    bhr_op_t op;
    logic ra_zero;
    logic [63:0] ra_val;
    logic [63:0] rb_val;
    logic [63:0] rs_val;
    logic [4:0] rt_idx;
    logic so_bit;
  } bhr_req_t;

  // one access to the data memory system
  typedef struct packed {
    logic wr;
    logic half;
    logic [63:0] ea;
    logic [15:0] wdata;
  } bhr_mem_t;

  // completion back to the pipeline
  typedef struct packed {
    logic is_load;
    logic align_err;
    logic [4:0] rt_idx;
    logic [63:0] rt_data;
    logic [3:0] cond_field_zero;
  } bhr_rsp_t;
endpackage : bhr_pkg

/* rtl/bhr_ea_calc.sv */
// effective address former for the reserve and conditional instructions
`timescale 1ns/10ps
`include "bhr_consts.svh"
module bhr_ea_calc import bhr_pkg::*; (
  input wire logic ra_zero_i,
  input wire logic [63:0] ra_val_i,
  input wire logic [63:0] rb_val_i,
  input wire logic half_i,
  output logic [63:0] ea_o,
  output logic misalign_o
);
  // ==========================================
  // address sum
  // the upper word is forced to zero; only the low word of the sum survives
  wire logic [63:0] base_val = ra_zero_i ? 64'h0 : ra_val_i;
  wire logic [63:0] sum_val = base_val + rb_val_i;
  assign ea_o = {32'h0, sum_val[31:0]};  // [R1]
  assign misalign_o = half_i & sum_val[0];  // [R5]
endmodule : bhr_ea_calc

/* rtl/bhr_rsv_track.sv */
// reservation flag and address holder
`timescale 1ns/10ps
`include "bhr_consts.svh"
module bhr_rsv_track import bhr_pkg::*; #(
  parameter int ADDR_W = 64
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic set_i,
  input wire logic clr_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [ADDR_W-1:0] cmp_addr_i,
  output logic valid_o,
  output logic match_o
);
  logic rsv_ff;
  logic [ADDR_W-1:0] raddr_ff;

  // ==========================================
  // reservation state
  // a set in the same cycle as a clear wins, so a new reservation is never lost
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rsv_ff <= `BHR_RSV_RST;  // [R13]
      raddr_ff <= '0;
    end else if (ce_i) begin
      if (set_i) begin
        rsv_ff <= 1'b1;  // [R4]
        raddr_ff <= addr_i;  // [R4]
      end else if (clr_i) begin
        rsv_ff <= 1'b0;
      end
    end
  end

  assign valid_o = rsv_ff;
  assign match_o = rsv_ff && (raddr_ff == cmp_addr_i);  // [R8]
endmodule : bhr_rsv_track

/* rtl/bhr_unit.sv */
// byte and halfword load-and-reserve / store-conditional unit
// Function
// [R1] effective address is 32 zero bits then low word of (base or 0) plus index
// [R2] byte reserve load fills bits 56:63, clears bits 0:55
// [R3] halfword reserve load fills bits 48:63, clears bits 0:47
// [R4] every reserve load sets the flag and replaces the held address; an odd-address halfword load that faults sets neither here
// [R5] odd halfword address raises an alignment fault
// [R6] byte conditional with matching reservation stores source byte, clears reservation
// [R7] halfword conditional with matching reservation stores source halfword, clears reservation
// [R8] match compares held address with translated real address of the store
// [R9] mismatching reservation is cleared; this unit does not store then
// [R10] no reservation: no memory change, report not performed
// [R11] condition field zero gets 00, store-performed, then summary overflow copy
// [R12] same behaviour as word reserve/conditional apart from access size
// [R13] reset clears the reservation flag
`timescale 1ns/10ps
`include "bhr_consts.svh"
module bhr_unit import bhr_pkg::*; #(
  parameter int TIMEOUT = `BHR_MEM_TIMEOUT
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire bhr_req_t req_i,
  output logic req_ready_o,
  input wire logic [63:0] real_addr_i,
  output logic mem_valid_o,
  output bhr_mem_t mem_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  output logic rsp_valid_o,
  output bhr_rsp_t rsp_o
);
  typedef enum logic [1:0] {
    BHR_ST_IDLE,
    BHR_ST_MEM,
    BHR_ST_DONE
  } bhr_state_t;

  bhr_state_t state_ff;
  bhr_state_t nxt_state;
  bhr_req_t req_ff;
  logic [63:0] ea_ff;
  logic [63:0] real_ff;
  logic req_ready_ff;
  logic mem_valid_ff;
  bhr_mem_t mem_ff;
  logic rsp_valid_ff;
  bhr_rsp_t rsp_ff;

  // ==========================================
  // address and reservation helpers
  logic [63:0] ea_w;
  logic misalign_w;
  logic rsv_valid_w;
  logic rsv_match_w;

  wire logic is_half_w = (req_i.op == BHR_OP_LHR) || (req_i.op == BHR_OP_SHC);
  wire logic is_load_w = (req_i.op == BHR_OP_LBR) || (req_i.op == BHR_OP_LHR);
  wire logic take_w = (state_ff == BHR_ST_IDLE) && req_valid_i && req_ready_ff;

  bhr_ea_calc u_ea (
    .ra_zero_i(req_i.ra_zero),
    .ra_val_i(req_i.ra_val),
    .rb_val_i(req_i.rb_val),
    .half_i(is_half_w),
    .ea_o(ea_w),
    .misalign_o(misalign_w)
  );

  // decisions at issue; conditional stores compare against the translated address
  wire logic load_ok_w = take_w && is_load_w && !misalign_w;
  wire logic cond_w = take_w && !is_load_w && !misalign_w;
  wire logic do_store_w = cond_w && rsv_match_w;  // [R6] [R7] [R9]
  wire logic rsv_clr_w = cond_w && rsv_valid_w;  // [R6] [R7] [R9]
  wire logic fault_w = take_w && misalign_w;  // [R5]

  bhr_rsv_track #(.ADDR_W(64)) u_rsv (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .set_i(load_ok_w),
    .clr_i(rsv_clr_w),
    .addr_i(real_addr_i),
    .cmp_addr_i(real_addr_i),
    .valid_o(rsv_valid_w),
    .match_o(rsv_match_w)
  );

  // condition field zero builder
  function automatic logic [3:0] cf0(input logic done, input logic so);
    cf0 = {2'b00, done, so};  // [R11]
  endfunction : cf0

  // load data extension, size the only difference from word forms
  function automatic logic [63:0] zext(input logic half, input logic [15:0] d);
    zext = half ? {48'h0, d} : {56'h0, d[7:0]};  // [R2] [R3] [R12]
  endfunction : zext

  // ==========================================
  // memory watchdog: a lost acknowledge must not hang the pipeline
  localparam int CNT_W = $clog2(TIMEOUT + 1);
  logic [CNT_W-1:0] wait_ff;
  wire logic timeout_w = (state_ff == BHR_ST_MEM) && (wait_ff == CNT_W'(TIMEOUT));

  // ==========================================
  // next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      BHR_ST_IDLE: begin
        if (load_ok_w || do_store_w) begin
          nxt_state = BHR_ST_MEM;
        end else if (take_w) begin
          nxt_state = BHR_ST_DONE;
        end
      end
      BHR_ST_MEM: begin
        if (mem_ack_i || timeout_w) begin
          nxt_state = BHR_ST_DONE;
        end
      end
      BHR_ST_DONE: begin
        nxt_state = BHR_ST_IDLE;
      end
    endcase
  end

  // ==========================================
  // state and captured request
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_ff <= BHR_ST_IDLE;
      req_ff <= '0;
      ea_ff <= '0;
      real_ff <= '0;
      wait_ff <= '0;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      wait_ff <= (state_ff == BHR_ST_MEM) ? wait_ff + CNT_W'(1) : '0;
      if (take_w) begin
        req_ff <= req_i;
        ea_ff <= ea_w;
        real_ff <= real_addr_i;
      end
    end
  end

  // ==========================================
  // pipeline handshake: one instruction in flight at a time
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      req_ready_ff <= 1'b0;
    end else if (ce_i) begin
      req_ready_ff <= (nxt_state == BHR_ST_IDLE) && !take_w;
    end
  end

  // ==========================================
  // memory request, held until acknowledged or the watchdog times out
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mem_valid_ff <= 1'b0;
      mem_ff <= '0;
    end else if (ce_i) begin
      if (load_ok_w || do_store_w) begin
        mem_valid_ff <= 1'b1;
        mem_ff.wr <= do_store_w;  // [R6] [R7]
        mem_ff.half <= is_half_w;
        mem_ff.ea <= ea_w;
        mem_ff.wdata <= is_half_w ? req_i.rs_val[15:0] : {8'h00, req_i.rs_val[7:0]};  // [R6] [R7]
      end else if (mem_ack_i || timeout_w) begin
        mem_valid_ff <= 1'b0;
      end
    end
  end

  // ==========================================
  // completion toward the pipeline
  // a conditional that skipped memory reports not performed [R10]
  wire logic st_done_w = (state_ff == BHR_ST_MEM) && req_ff.op inside {BHR_OP_SBC, BHR_OP_SHC};
  wire logic ld_w = req_ff.op inside {BHR_OP_LBR, BHR_OP_LHR};
  wire logic rhalf_w = req_ff.op inside {BHR_OP_LHR, BHR_OP_SHC};
  logic fault_ff;
  // marks, from issue, that this instruction was sent to memory and is answered by the memory path
  logic st_done_pend_ff;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      fault_ff <= 1'b0;
    end else if (ce_i && take_w) begin
      fault_ff <= fault_w;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rsp_valid_ff <= 1'b0;
      rsp_ff <= '0;
    end else if (ce_i) begin
      rsp_valid_ff <= 1'b0;
      if ((state_ff == BHR_ST_MEM) && (mem_ack_i || timeout_w)) begin
        rsp_valid_ff <= 1'b1;
        rsp_ff.is_load <= ld_w;
        rsp_ff.align_err <= timeout_w && !mem_ack_i;
        rsp_ff.rt_idx <= req_ff.rt_idx;
        rsp_ff.rt_data <= ld_w ? zext(rhalf_w, mem_rdata_i) : 64'h0;  // [R2] [R3]
        rsp_ff.cond_field_zero <= ld_w ? 4'h0 : cf0(st_done_w && mem_ack_i, req_ff.so_bit);  // [R11]
      end else if (state_ff == BHR_ST_DONE && !rsp_valid_ff && nxt_state == BHR_ST_IDLE
                   && !(mem_valid_ff)) begin
        if (!st_done_pend_ff) begin
          rsp_valid_ff <= 1'b1;
          rsp_ff.is_load <= ld_w;
          rsp_ff.align_err <= fault_ff;  // [R5]
          rsp_ff.rt_idx <= req_ff.rt_idx;
          rsp_ff.rt_data <= 64'h0;
          rsp_ff.cond_field_zero <= ld_w ? 4'h0 : cf0(1'b0, req_ff.so_bit);  // [R10] [R11]
        end
      end
    end
  end

  // pending flag: the early answer path must stay quiet for memory instructions
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_done_pend_ff <= 1'b0;
    end else if (ce_i) begin
      if (take_w) begin
        st_done_pend_ff <= load_ok_w || do_store_w;
      end
    end
  end

  assign req_ready_o = req_ready_ff;
  assign mem_valid_o = mem_valid_ff;
  assign mem_o = mem_ff;
  assign rsp_valid_o = rsp_valid_ff;
  assign rsp_o = rsp_ff;
endmodule : bhr_unit

/* tb/bhr_unit_sva.sv */
// port checker for the reservation unit
`timescale 1ns/10ps
module bhr_unit_sva import bhr_pkg::*; #(
  parameter int TIMEOUT = 16
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire bhr_req_t req_i,
  input wire logic req_ready_o,
  input wire logic [63:0] real_addr_i,
  input wire logic mem_valid_o,
  input wire bhr_mem_t mem_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic rsp_valid_o,
  input wire bhr_rsp_t rsp_o
);
  logic so_ff;
  wire st_rsp = rsp_valid_o && !rsp_o.is_load;
  // overflow copy of the taken request, kept for its answer
  always_ff @(posedge mclk_i) if (req_valid_i && req_ready_o && ce_i) so_ff <= req_i.so_bit;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // =====
  // rules
  a_rst_quiet: assert property (disable iff (1'b0) srst_i |=> !rsp_valid_o && !mem_valid_o)
    else $error("output active after reset");
  a_ea_upper: assert property (mem_valid_o |-> mem_o.ea[63:32] == 32'h0)
    else $error("upper address bits set");
  a_half_align: assert property (mem_valid_o && mem_o.half |-> !mem_o.ea[0])
    else $error("odd halfword access issued");
  a_load_zext: assert property (rsp_valid_o && rsp_o.is_load && !rsp_o.align_err |-> rsp_o.rt_data[63:16] == 48'h0)
    else $error("load not zero extended");
  a_cond_high: assert property (st_rsp |-> rsp_o.cond_field_zero[3:2] == 2'b00)
    else $error("lt/gt bits not clear");
  a_so_copy: assert property (st_rsp |-> rsp_o.cond_field_zero[0] == so_ff)
    else $error("overflow copy wrong");
  a_store_done: assert property (mem_valid_o && mem_o.wr && mem_ack_i && ce_i |=> st_rsp && rsp_o.cond_field_zero[1])
    else $error("performed store not reported");
  a_busy_refuse: assert property (mem_valid_o |-> !req_ready_o)
    else $error("ready while memory busy");
  a_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("answer longer than one cycle");
  c_store_hit: cover property (st_rsp && rsp_o.cond_field_zero[1]);
  c_align: cover property (rsp_valid_o && rsp_o.align_err);
  c_load: cover property (rsp_valid_o && rsp_o.is_load);
endmodule : bhr_unit_sva
bind bhr_unit bhr_unit_sva #(.TIMEOUT(TIMEOUT)) u_sva (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .real_addr_i(real_addr_i),
  .mem_valid_o(mem_valid_o), .mem_o(mem_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
  .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));

/* tb/bhr_mem_model.sv */
// data memory responder, big-endian halfwords
`timescale 1ns/10ps
module bhr_mem_model import bhr_pkg::*; (
  input wire logic mclk_i,
  input wire logic [1:0] dly_i,
  input wire logic mem_valid_i,
  input wire bhr_mem_t mem_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o
);
  logic [7:0] mem_q [longint];
  int cnt = 0;
  function automatic logic [7:0] rd(longint a);
    return mem_q.exists(a) ? mem_q[a] : a[7:0] ^ 8'h5a;
  endfunction : rd
  initial begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 16'h0;
  end
  // acks after dly_i cycles; read lines toggle otherwise so stale data never passes
  always @(posedge mclk_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (mem_valid_i && !mem_ack_o) begin
      if (cnt < dly_i) cnt++;
      else begin
        cnt = 0;
        mem_ack_o <= 1'b1;
        mem_rdata_o <= mem_i.half ? {rd(mem_i.ea), rd(mem_i.ea + 1)} : {~rd(mem_i.ea), rd(mem_i.ea)};
        if (mem_i.wr && mem_i.half) begin
          mem_q[mem_i.ea] = mem_i.wdata[15:8];
          mem_q[mem_i.ea + 1] = mem_i.wdata[7:0];
        end else if (mem_i.wr) mem_q[mem_i.ea] = mem_i.wdata[7:0];
      end
    end
  end
endmodule : bhr_mem_model

/* tb/testbench.sv */
// self-checking bench for the byte/halfword reservation unit
`timescale 1ns/10ps
module testbench import bhr_pkg::*;;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b0;
  logic req_valid_i = 1'b0;
  bhr_req_t req_i = '0;
  logic [63:0] real_addr_i = 64'h0;
  logic [1:0] dly = 2'h0;
  logic req_ready_o, mem_valid_o, mem_ack_i, rsp_valid_o;
  logic [15:0] mem_rdata_i;
  bhr_mem_t mem_o;
  bhr_rsp_t rsp_o;
  int n_fail = 0;
  int cmp_count = 0;
  logic rsv_v = 1'b0;
  logic [63:0] rsv_a;
  logic [7:0] tb_mem [longint];
  always #20 mclk_i = ~mclk_i;
  bhr_unit #(.TIMEOUT(16)) dut (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .real_addr_i(real_addr_i), .mem_valid_o(mem_valid_o),
    .mem_o(mem_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));
  bhr_mem_model u_mem (.mclk_i(mclk_i), .dly_i(dly), .mem_valid_i(mem_valid_o), .mem_i(mem_o),
    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
  task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  function automatic logic [7:0] mb(longint a);
    return tb_mem.exists(a) ? tb_mem[a] : a[7:0] ^ 8'h5a;
  endfunction : mb
  // one instruction: drive at falling edge, hold until taken, then judge the answer
  task automatic do_op(bhr_op_t op, logic [31:0] ea32, logic rz, logic [63:0] rs, logic so, logic [63:0] xo);
    logic [63:0] ea, ra, rl;
    logic hf, perf;
    int n;
    ea = {32'h0, ea32};
    rl = ea ^ xo;
    ra = {$urandom, $urandom};
    hf = op inside {BHR_OP_LHR, BHR_OP_SHC};
    req_i = '{op: op, ra_zero: rz, ra_val: ra, rb_val: {$urandom, ea32 - (rz ? 32'h0 : ra[31:0])},
      rs_val: rs, rt_idx: 5'h3, so_bit: so};
    real_addr_i = rl;
    req_valid_i = 1'b1;
    n = 0;
    while (!req_ready_o) begin
      @(negedge mclk_i);
      if (++n > 50) begin n_fail++; wrap_up(); end
    end
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    n = 0;
    while (!rsp_valid_o) begin
      @(negedge mclk_i);
      if (++n > 50) begin n_fail++; wrap_up(); end
    end
    check("rt_idx", rsp_o.rt_idx, 64'h3);
    check("is_load", rsp_o.is_load, {63'h0, !op[1]});
    if (hf && ea[0]) check("align", rsp_o.align_err, 64'h1);
    else if (!op[1]) begin
      check("load", rsp_o.rt_data, hf ? {48'h0, mb(ea), mb(ea + 1)} : {56'h0, mb(ea)});
      rsv_v = 1'b1;
      rsv_a = rl;
    end else begin
      perf = rsv_v && rsv_a == rl;
      if (perf && hf) begin
        tb_mem[ea] = rs[15:8];
        tb_mem[ea + 1] = rs[7:0];
      end else if (perf) tb_mem[ea] = rs[7:0];
      rsv_v = 1'b0;
      check("cond", rsp_o.cond_field_zero, {2'b00, perf, so});
    end
    @(negedge mclk_i);
  endtask : do_op
  // =====
  // directed cases, then a random mix over a few shared addresses
  initial begin
    void'($urandom(32'h911b12c7));
    repeat (8) @(negedge mclk_i);
    srst_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    ce_i = 1'b1;
    do_op(BHR_OP_SBC, 32'h100, 1'b0, 64'h11, 1'b1, 64'h0);
    do_op(BHR_OP_LBR, 32'h100, 1'b1, 64'h0, 1'b0, 64'h0);
    do_op(BHR_OP_LHR, 32'h102, 1'b0, 64'h0, 1'b0, 64'h0);
    do_op(BHR_OP_SBC, 32'h100, 1'b0, 64'h22, 1'b1, 64'h0);
    do_op(BHR_OP_LHR, 32'h142, 1'b0, 64'h0, 1'b0, 64'h0);
    do_op(BHR_OP_SHC, 32'h102, 1'b0, 64'h1234_5678_9abc_beef, 1'b0, 64'h40);
    do_op(BHR_OP_LBR, 32'h101, 1'b0, 64'h0, 1'b0, 64'h0);
    do_op(BHR_OP_SBC, 32'h101, 1'b1, 64'hffee_ddcc_bbaa_99a5, 1'b1, 64'h0);
    do_op(BHR_OP_LHR, 32'h100, 1'b0, 64'h0, 1'b0, 64'h0);
    srst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    srst_i = 1'b0;
    rsv_v = 1'b0;
    do_op(BHR_OP_SHC, 32'h100, 1'b0, 64'h77, 1'b0, 64'h0);
    repeat (80) begin
      dly = 2'($urandom);
      do_op(bhr_op_t'(2'($urandom)), 32'h100 + 32'($urandom % 2) * 32'h40 + 32'($urandom % 3),
        1'($urandom), {$urandom, $urandom}, 1'($urandom), ($urandom % 2) ? 64'h40 : 64'h0);
    end
    wrap_up();
  end
endmodule : testbench
